// ==== core/cbs_defines.vh ====
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH

// ----------------------------------------------------------------
// machine cycle kinds
// ----------------------------------------------------------------
`define CBS_TY_OF      3'h0
`define CBS_TY_MR      3'h1
`define CBS_TY_MW      3'h2
`define CBS_TY_IOW     3'h3
`define CBS_TY_INA     3'h4
`define CBS_TY_BI      3'h5
`define CBS_TY_RSF     3'h6

// ----------------------------------------------------------------
// status codes {io_memory_select, upper, lower}
// ----------------------------------------------------------------
`define CBS_STAT_OF    3'h3
`define CBS_STAT_MR    3'h2
`define CBS_STAT_MW    3'h1
`define CBS_STAT_IOW   3'h5
`define CBS_STAT_INA   3'h7
`define CBS_STAT_HALT  3'h0

// ----------------------------------------------------------------
// acknowledge call sequence phases
// ----------------------------------------------------------------
`define CBS_SQ_NONE    3'h0
`define CBS_SQ_CALL_LO 3'h1
`define CBS_SQ_CALL_HI 3'h2
`define CBS_SQ_PUSH_HI 3'h3
`define CBS_SQ_PUSH_LO 3'h4

// ----------------------------------------------------------------
// pending interrupt kinds
// ----------------------------------------------------------------
`define CBS_PK_NONE    2'h0
`define CBS_PK_TRAP    2'h1
`define CBS_PK_RST     2'h2
`define CBS_PK_MASKABLE_INTERRUPT_REQUEST    2'h3

// ----------------------------------------------------------------
// opcodes and vectors
// ----------------------------------------------------------------
`define CBS_OP_CALL    8'hCD
`define CBS_OP_RST_HI  8'hFF
`define CBS_VEC_RST_HI 16'h003C
`define CBS_VEC_TRAP   16'h0024

`endif

// ==== core/cbs_sync.v ====
// ----------------------------------------------------------------
// three stage synchroniser, a bit changes once stages 2 and 3 agree
// ----------------------------------------------------------------
module cbs_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,   // system clock
  input  wire         rstn,      // synchronous reset, active low
  input  wire [W-1:0] d_async,   // pins from outside the clock domain
  output reg  [W-1:0] q          // filtered, synchronised level
);

  reg [W-1:0] sync1;
  reg [W-1:0] sync2;
  reg [W-1:0] sync3;

  // stage 1 feeds stage 2 only, so metastability never reaches logic
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sync1 <= {W{1'b0}};
      sync2 <= {W{1'b0}};
      sync3 <= {W{1'b0}};
      q     <= {W{1'b0}};
    end else begin
      sync1 <= d_async;
      sync2 <= sync1;
      sync3 <= sync2;
      q     <= (sync3 & ~(sync2 ^ sync3)) | (q & (sync2 ^ sync3));
    end
  end

endmodule

// ==== core/cbs_irq.v ====
`include "cbs_defines.vh"

// ----------------------------------------------------------------
// interrupt edge latches and priority choice
// ----------------------------------------------------------------
module cbs_irq (
  input  wire       clk_sys,    // system clock
  input  wire       rstn,       // synchronous reset, active low
  input  wire       trap_lvl,   // synchronised nonmaskable input
  input  wire       rsthi_lvl,  // synchronised highest restart input
  input  wire       maskable_interrupt_request_lvl,   // synchronised maskable request
  input  wire       inte,       // interrupt enable flag
  input  wire       rst_mask,   // restart input mask
  input  wire       clr_trap,   // pulse, nonmaskable accepted
  input  wire       clr_rst,    // pulse, restart accepted
  output reg  [1:0] kind        // highest valid interrupt now
);

  reg trap_prev;
  reg rst_prev;
  reg trap_lat;
  reg rst_lat;

  // edges set the latches; an edge in the clearing cycle still sets
  always @(posedge clk_sys) begin
    if (!rstn) begin
      trap_prev <= 1'b0;
      rst_prev  <= 1'b0;
      trap_lat  <= 1'b0;
      rst_lat   <= 1'b0;
    end else begin
      trap_prev <= trap_lvl;
      rst_prev  <= rsthi_lvl;
      trap_lat  <= (trap_lvl & ~trap_prev) | (trap_lat & ~clr_trap);
      rst_lat   <= (rsthi_lvl & ~rst_prev) | (rst_lat & ~clr_rst);
    end
  end

  // nonmaskable first; maskable request only when nothing else valid
  always @* begin
    if (trap_lat && trap_lvl)
      kind = `CBS_PK_TRAP;
    else if (rst_lat && inte && !rst_mask)
      kind = `CBS_PK_RST;
    else if (maskable_interrupt_request_lvl && inte)
      kind = `CBS_PK_MASKABLE_INTERRUPT_REQUEST;
    else
      kind = `CBS_PK_NONE;
  end

endmodule

// ==== core/cbs_seq.v ====
`include "cbs_defines.vh"

// Overview of operation
// - memory write T1 status: select low, upper low, lower high
// - write keeps data drivers on, data and write strobe at T2
// - ready sampled in T2; low inserts wait states until high
// - write strobe rises in T3; address and data hold to next T1 (data lines here are driven through T3 only, then float if no T1 follows)
// - write data stable around strobe rise; capture there
// - port write timed as memory write, select driven high
// - port write puts port number on both address bytes
// - interrupts sampled second clock before each opcode T1
// - only maskable request and flag set: clear flag, acknowledge
// - acknowledge is a fetch with acknowledge strobe, select high
// - further acknowledge cycles fetch later bytes, three T each
// - program counter not advanced during acknowledge cycles
// - call: push high then low PC, load bytes two and three
// - register pair add idle cycles: no read, no latch, no ready
// - restart: fetch without read strobe, own opcode, vector 3CH
// - restart edge sets latch, sampled before last T-state
// - halt floats the bus; reset always forces reset state
// - interrupt in halt clears flag, goes to T1 of fetch
// - hold in halt enters hold state, then back to halt
// - halt samples latch every state, leaves one period later
// - address latch strobe in T1 with low address on bus
// - status tells fetch, memory read and other cycle kinds
module cbs_seq (
  input  wire        clk_sys,         // 10 MHz, one T-state a cycle
  input  wire        rstn,            // synchronous reset, active low
  // core side
  input  wire        req,             // cycle request, level
  input  wire [2:0]  req_type,        // cycle kind
  input  wire [15:0] req_addr,        // address, port in low byte
  input  wire [7:0]  req_wdata,       // write data
  input  wire        fetch_next,      // next cycle will be a fetch
  input  wire        halt_req,        // enter halt instead of a cycle
  input  wire        ei_set,          // pulse, enable interrupts
  input  wire        di_set,          // pulse, disable interrupts
  input  wire        rst_mask,        // mask of the restart input
  input  wire [15:0] pc_now,          // current program counter
  input  wire [15:0] sp_now,          // current stack pointer
  output wire        req_ready,       // request taken this edge
  output reg         cyc_done,        // pulse, cycle or sequence done
  output reg  [7:0]  cyc_rdata,       // byte read or opcode
  output reg         vec_valid,       // pulse, internal restart
  output reg  [15:0] vec_addr,        // restart target
  output reg         pc_load,         // pulse, load pc_new and sp_new
  output reg  [15:0] pc_new,          // call target
  output reg  [15:0] sp_new,          // stack after two pushes
  output reg         pc_inc,          // pulse, advance program counter
  output reg         interrupt_enable_flag, // interrupt enable
  output wire        halted,          // in halt or hold
  // bus pins
  input  wire [7:0]  ad_in,           // muxed lines, read side
  output reg  [7:0]  muxed_addr_data_low, // muxed lines, drive side
  output wire        ad_oe,           // muxed lines enable
  output reg  [7:0]  address_high,    // upper address byte
  output wire        ctl_oe,          // enable of address and control
  output wire        ale,             // address latch strobe
  output wire        rd_n,            // read strobe, active low
  output wire        write_strobe_n,  // write strobe, active low
  output wire        acknowledge_strobe_n, // acknowledge, active low
  output wire        io_memory_select,    // high for port cycles
  output wire        cycle_status_upper,  // status bit
  output wire        cycle_status_lower,  // status bit
  input  wire        ready,           // synchronous bus ready
  input  wire        hold,            // bus hold request, async
  output wire        hlda,            // hold acknowledge
  input  wire        maskable_interrupt_request, // async
  input  wire        nmi_in,          // nonmaskable input, async
  input  wire        rst_hi_in        // highest restart input, async
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_T1   = 3'h1;
  localparam ST_T2   = 3'h2;
  localparam ST_TW   = 3'h3;
  localparam ST_T3   = 3'h4;
  localparam ST_T4   = 3'h5;
  localparam ST_HALT = 3'h6;
  localparam ST_HOLD = 3'h7;

  reg  [2:0]  st;
  reg  [2:0]  ty;
  reg         cur_long;
  reg  [7:0]  cur_wdata;
  reg  [2:0]  seq;
  reg  [1:0]  pend;
  reg  [1:0]  disp_kind;
  reg  [7:0]  call_lo;
  reg  [15:0] ret_pc;
  reg  [15:0] ret_sp;
  wire [2:0]  sync_out;
  wire [1:0]  irq_kind;

  // ----------------------------------------------------------------
  // input synchronisers and interrupt latches
  // ----------------------------------------------------------------
  cbs_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d_async ({hold, nmi_in, rst_hi_in}),
    .q       (sync_out)
  );

  wire hold_s = sync_out[2];
  wire maskable_interrupt_request_s;
  wire clr_trap;
  wire clr_rst;

  cbs_sync #(.W(1)) u_sync_maskable_interrupt_request (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d_async (maskable_interrupt_request),
    .q       (maskable_interrupt_request_s)
  );

  cbs_irq u_irq (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .trap_lvl  (sync_out[1]),
    .rsthi_lvl (sync_out[0]),
    .maskable_interrupt_request_lvl  (maskable_interrupt_request_s),
    .inte      (interrupt_enable_flag),
    .rst_mask  (rst_mask),
    .clr_trap  (clr_trap),
    .clr_rst   (clr_rst),
    .kind      (irq_kind)
  );

  // ----------------------------------------------------------------
  // cycle end and next cycle choice
  // ----------------------------------------------------------------
  wire is_rd   = (ty == `CBS_TY_OF) || (ty == `CBS_TY_MR);
  wire is_wr   = (ty == `CBS_TY_MW) || (ty == `CBS_TY_IOW);
  wire no_rdy  = (ty == `CBS_TY_BI) || (ty == `CBS_TY_RSF);
  wire rdy_ok  = ready || no_rdy;
  wire cyc_end = (st == ST_T4) || (st == ST_T3 && !cur_long);
  wire at_gap  = cyc_end || (st == ST_IDLE);
  // second clock before the next T1
  wire penult  = (st == ST_T3 && cur_long) ||
                 ((st == ST_T2 || st == ST_TW) && rdy_ok && !cur_long);
  wire samp    = (fetch_next && (penult || st == ST_IDLE)) ||
                 st == ST_HALT || st == ST_HOLD;

  reg  [2:0]  next_seq;
  reg         go;
  reg  [2:0]  g_ty;
  reg  [15:0] g_addr;
  reg  [7:0]  g_wd;
  reg         g_long;
  reg         g_disp;
  reg         take_req;

  // next phase of the acknowledge call sequence
  always @* begin
    next_seq = seq;
    if (cyc_end) begin
      case (seq)
        `CBS_SQ_NONE: begin
          if (ty == `CBS_TY_INA && cyc_rdata == `CBS_OP_CALL)
            next_seq = `CBS_SQ_CALL_LO;
        end
        `CBS_SQ_CALL_LO: next_seq = `CBS_SQ_CALL_HI;
        `CBS_SQ_CALL_HI: next_seq = `CBS_SQ_PUSH_HI;
        `CBS_SQ_PUSH_HI: next_seq = `CBS_SQ_PUSH_LO;
        default:         next_seq = `CBS_SQ_NONE;
      endcase
    end
  end

  // descriptor of the cycle that starts at this edge, if any
  always @* begin
    go       = 1'b0;
    take_req = 1'b0;
    g_disp   = 1'b0;
    g_ty     = `CBS_TY_OF;
    g_addr   = pc_now;
    g_wd     = 8'h00;
    g_long   = 1'b1;
    if (at_gap && next_seq != `CBS_SQ_NONE) begin
      go = 1'b1;
      case (next_seq)
        `CBS_SQ_PUSH_HI: begin
          g_ty   = `CBS_TY_MW;
          g_addr = ret_sp - 16'h0001;
          g_wd   = ret_pc[15:8];
          g_long = 1'b0;
        end
        `CBS_SQ_PUSH_LO: begin
          g_ty   = `CBS_TY_MW;
          g_addr = ret_sp - 16'h0002;
          g_wd   = ret_pc[7:0];
          g_long = 1'b0;
        end
        default: begin
          g_ty   = `CBS_TY_INA;
          g_addr = ret_pc;
          g_long = 1'b0;
        end
      endcase
    end else if (st == ST_HALT && !hold_s && pend != `CBS_PK_NONE) begin
      go     = 1'b1;
      g_disp = 1'b1;
    end else if (at_gap && !halt_req && req) begin
      go       = 1'b1;
      take_req = 1'b1;
      g_ty     = req_type;
      g_addr   = req_addr;
      g_wd     = req_wdata;
      g_long   = (req_type == `CBS_TY_OF);
      if (req_type == `CBS_TY_IOW)
        g_addr = {req_addr[7:0], req_addr[7:0]};
      if (req_type == `CBS_TY_OF && pend != `CBS_PK_NONE)
        g_disp = 1'b1;
    end
    // a fetch with an interrupt pending becomes its response
    if (g_disp) begin
      g_addr = pc_now;
      g_long = 1'b1;
      if (pend == `CBS_PK_MASKABLE_INTERRUPT_REQUEST)
        g_ty = `CBS_TY_INA;
      else
        g_ty = `CBS_TY_RSF;
    end
  end

  assign req_ready = take_req;
  assign clr_trap  = g_disp && pend == `CBS_PK_TRAP;
  assign clr_rst   = g_disp && pend == `CBS_PK_RST;

  // ----------------------------------------------------------------
  // T-state machine
  // ----------------------------------------------------------------
  // reset wins over everything, including halt and hold
  always @(posedge clk_sys) begin
    if (!rstn) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_T1:   st <= ST_T2;
        ST_T2:   st <= rdy_ok ? ST_T3 : ST_TW;
        ST_TW:   st <= rdy_ok ? ST_T3 : ST_TW;
        ST_HOLD: st <= hold_s ? ST_HOLD : ST_HALT;
        ST_HALT: begin
          if (hold_s)
            st <= ST_HOLD;
          else if (go)
            st <= ST_T1;
        end
        default: begin
          if (st == ST_T3 && cur_long)
            st <= ST_T4;
          else if (go)
            st <= ST_T1;               // next T1 follows at once
          else if (halt_req && at_gap && seq == `CBS_SQ_NONE)
            st <= ST_HALT;
          else if (at_gap)
            st <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cycle registers, bus address and data
  // ----------------------------------------------------------------
  // address and data only change on entry to T1 and, for writes, T2
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ty                  <= `CBS_TY_OF;
      cur_long            <= 1'b0;
      cur_wdata           <= 8'h00;
      muxed_addr_data_low <= 8'h00;
      address_high        <= 8'h00;
      seq                 <= `CBS_SQ_NONE;
      disp_kind           <= `CBS_PK_NONE;
    end else begin
      seq <= next_seq;
      if (go) begin
        ty                  <= g_ty;
        cur_long            <= g_long;
        cur_wdata           <= g_wd;
        muxed_addr_data_low <= g_addr[7:0];
        address_high        <= g_addr[15:8];
        disp_kind           <= g_disp ? pend : `CBS_PK_NONE;
      end else if (st == ST_T1 && is_wr) begin
        muxed_addr_data_low <= cur_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt sampling and enable flag
  // ----------------------------------------------------------------
  // first accepted interrupt is kept; later sampling cannot replace it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pend                  <= `CBS_PK_NONE;
      interrupt_enable_flag <= 1'b0;
    end else begin
      if (g_disp)
        pend <= `CBS_PK_NONE;
      else if (samp && pend == `CBS_PK_NONE)
        pend <= irq_kind;
      if (g_disp || di_set)
        interrupt_enable_flag <= 1'b0;
      else if (ei_set)
        interrupt_enable_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // results handed back to the core
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cyc_done  <= 1'b0;
      cyc_rdata <= 8'h00;
      vec_valid <= 1'b0;
      vec_addr  <= 16'h0000;
      pc_load   <= 1'b0;
      pc_new    <= 16'h0000;
      sp_new    <= 16'h0000;
      pc_inc    <= 1'b0;
      call_lo   <= 8'h00;
      ret_pc    <= 16'h0000;
      ret_sp    <= 16'h0000;
    end else begin
      cyc_done  <= 1'b0;
      vec_valid <= 1'b0;
      pc_load   <= 1'b0;
      pc_inc    <= 1'b0;
      // return address frozen while acknowledge cycles run
      if (g_disp) begin
        ret_pc <= pc_now;
        ret_sp <= sp_now;
      end
      if (st == ST_T3 && (is_rd || ty == `CBS_TY_INA)) begin
        if (seq == `CBS_SQ_CALL_LO)
          call_lo <= ad_in;
        else if (seq == `CBS_SQ_CALL_HI)
          pc_new <= {ad_in, call_lo};
        else
          cyc_rdata <= ad_in;
      end
      if (st == ST_T3 && ty == `CBS_TY_RSF) begin
        cyc_rdata <= `CBS_OP_RST_HI;
        vec_valid <= 1'b1;
        if (disp_kind == `CBS_PK_TRAP)
          vec_addr <= `CBS_VEC_TRAP;
        else
          vec_addr <= `CBS_VEC_RST_HI;
      end
      if (cyc_end) begin
        if (ty == `CBS_TY_OF)
          pc_inc <= 1'b1;
        if (seq == `CBS_SQ_PUSH_LO) begin
          pc_load  <= 1'b1;
          sp_new   <= ret_sp - 16'h0002;
          cyc_done <= 1'b1;
        end else if (next_seq == `CBS_SQ_NONE) begin
          cyc_done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus strobes, enables and status
  // ----------------------------------------------------------------
  wire in_act = (st == ST_T1) || (st == ST_T2) || (st == ST_TW) ||
                (st == ST_T3) || (st == ST_T4);
  wire strobe = (st == ST_T2) || (st == ST_TW) || (st == ST_T3);
  reg  [2:0] stat;

  // status stays on for the whole cycle
  always @* begin
    case (ty)
      `CBS_TY_MW:  stat = `CBS_STAT_MW;
      `CBS_TY_IOW: stat = `CBS_STAT_IOW;
      `CBS_TY_INA: stat = `CBS_STAT_INA;
      `CBS_TY_MR:  stat = `CBS_STAT_MR;
      `CBS_TY_BI:  stat = `CBS_STAT_MR;
      default:     stat = `CBS_STAT_OF;
    endcase
    if (!in_act)
      stat = `CBS_STAT_HALT;
  end

  // halt and hold float address, data and control
  assign ctl_oe = (st != ST_HALT) && (st != ST_HOLD);
  assign hlda   = (st == ST_HOLD);
  assign halted = !ctl_oe;
  assign ale    = (st == ST_T1) && (ty != `CBS_TY_BI);
  // write data stays driven through T3 past the strobe rise
  assign ad_oe  = (st == ST_T1) ||
                  (is_wr && strobe);
  assign rd_n   = !(strobe && is_rd);
  // strobe is high again in T3, which ends the write
  assign write_strobe_n = !(is_wr &&
                  (st == ST_T2 || st == ST_TW));
  assign acknowledge_strobe_n = !(strobe &&
                  ty == `CBS_TY_INA);
  assign io_memory_select   = stat[2];
  assign cycle_status_upper = stat[1];
  assign cycle_status_lower = stat[0];

endmodule

// ==== dv/cbs_seq_assertions.sv ====
// ------------------------------------------------------------
// pin level checks of the bus cycle sequencer
// ------------------------------------------------------------
module cbs_chk (
  input logic       clk_sys, rstn, ale, rd_n, write_strobe_n, ready,
  input logic       acknowledge_strobe_n, io_memory_select, halted,
  input logic       cycle_status_upper, cycle_status_lower, ad_oe, ctl_oe,
  input logic [7:0] muxed_addr_data_low, address_high
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [2:0] st = {io_memory_select, cycle_status_upper, cycle_status_lower};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // write cycles: start, waits, release with the data held
  AST_MW_T1:
    assert property (ale && st == 3'h1 |=> !write_strobe_n && ad_oe)
    else $error("memory write start wrong");
  AST_WAIT:
    assert property (!write_strobe_n && !ready |=> !write_strobe_n)
    else $error("wait state not inserted");
  AST_WR_END:
    assert property (!write_strobe_n && ready |=> write_strobe_n && ad_oe
                     && $stable(muxed_addr_data_low))
    else $error("write end or data hold wrong");
  AST_IOW:
    assert property (ale && st == 3'h5 |->
                     muxed_addr_data_low == address_high ##1 !write_strobe_n)
    else $error("port write address or strobe wrong");
  // latch strobe, memory read and acknowledge cycles, and the halt float
  AST_ALE:
    assert property (ale |-> ad_oe && ctl_oe && rd_n && write_strobe_n)
    else $error("latch strobe without low address");
  AST_MR:
    assert property (ale && st == 3'h2 |=> !rd_n && !ad_oe)
    else $error("memory read shape wrong");
  AST_ACK:
    assert property (!acknowledge_strobe_n |-> st == 3'h7 && rd_n && !ad_oe)
    else $error("acknowledge cycle wrong");
  AST_HALT:
    assert property (halted |-> !ad_oe && !ctl_oe)
    else $error("bus driven in halt");
endmodule
bind cbs_seq cbs_chk chk_u (.*);

// ==== dv/cbs_bus_model.sv ====
// ------------------------------------------------------------
// memory, ports and interrupt controller on the far side
// ------------------------------------------------------------
module cbs_bus_model (
  input  logic        clk_sys, ale, rd_n, write_strobe_n, slow,
  input  logic        acknowledge_strobe_n, io_memory_select,
  input  logic [7:0]  muxed_addr_data_low, address_high,
  output logic [7:0]  ad_in,
  output logic        ready, wr_ev,
  output logic [24:0] wr_rec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] a = '0;
  logic [7:0]  last = '0, val, op;
  logic [1:0]  k = '0, cnt = '0;
  logic        io = '0, wr_q = '1, ack_q = '1;
  wire drv  = !rd_n || !acknowledge_strobe_n;
  wire busy = !(rd_n && write_strobe_n && acknowledge_strobe_n);
  // call opcode, then low and high target bytes
  assign op  = k == 2'h0 ? 8'hCD : (k == 2'h1 ? 8'h34 : 8'h12);
  assign val = acknowledge_strobe_n ? a[7:0] ^ 8'h5A : op;
  // released lines show the inverse, so a stale byte never passes
  assign ad_in = drv ? val : ~last;
  assign ready = cnt == 2'h0;
  // latch address, stretch slow cycles, log data at strobe rise
  always @(posedge clk_sys) begin
    wr_q  <= write_strobe_n;
    ack_q <= acknowledge_strobe_n;
    wr_ev <= 1'b0;
    if (ale) begin
      a   <= {address_high, muxed_addr_data_low};
      io  <= io_memory_select;
      cnt <= slow ? 2'h2 : 2'h0;
    end else if (cnt != 2'h0 && busy)
      cnt <= cnt - 2'h1;
    if (drv)
      last <= val;
    if (write_strobe_n && !wr_q) begin
      wr_ev  <= 1'b1;
      wr_rec <= {io, a, muxed_addr_data_low};
    end
    if (acknowledge_strobe_n && !ack_q)
      k <= k + 2'h1;
  end
endmodule

// ==== dv/cbs_tb.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = '0, rstn = '0, req = '0, fetch_next = '0, halt_req = '0;
  logic ei_set = '0, di_set = '0, rst_mask = '0, hold = '0, slow = '0;
  logic maskable_interrupt_request = '0, nmi_in = '0, rst_hi_in = '0;
  logic [2:0]  req_type = '0, t;
  logic [7:0]  req_wdata = '0;
  logic [15:0] req_addr = '0, pc_now = 16'hABCD, sp_now = 16'h8000, a;
  logic [15:0] vhit = '0;
  logic [31:0] rs = 32'h31E4;
  logic [24:0] exp_q[$];
  int failures = 0, n_checks = 0, n, incs = 0;
  wire req_ready, cyc_done, vec_valid, pc_load, pc_inc, halted, hlda, ale;
  wire interrupt_enable_flag, ad_oe, ctl_oe, rd_n, ready, wr_ev;
  wire write_strobe_n, acknowledge_strobe_n, io_memory_select;
  wire cycle_status_upper, cycle_status_lower;
  wire [7:0]  cyc_rdata, muxed_addr_data_low, address_high, ad_in;
  wire [15:0] vec_addr, pc_new, sp_new;
  wire [24:0] wr_rec;
  cbs_seq       dut_u (.*);
  cbs_bus_model far_u (.*);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [24:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // request held until taken, so bursts run back to back
  task automatic cyc(input logic [2:0] ty, input logic [15:0] ad,
                     input logic [7:0] d, input logic fin);
    int w;
    req <= 1'b1;
    req_type <= ty;
    req_addr <= ad;
    req_wdata <= d;
    w = 0;
    // ready is combinational for the coming edge, so look mid-cycle
    do begin @(negedge clk_sys); w++; end
    while (req_ready !== 1'b1 && w < 60);
    if (w >= 60) failures++;
    step(1); // the edge that takes the request
    if (fin) begin
      req <= 1'b0;
      step(1); // skip the done of the cycle before
      w = 0;
      do begin @(negedge clk_sys); w++; end
      while (cyc_done !== 1'b1 && w < 200);
      if (w >= 200) failures++;
    end
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, write log and vector capture
  // ------------------------------------------------------------
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    step(30000);
    failures++;
    tally_and_finish;
  end
  always @(posedge clk_sys) begin
    if (pc_inc === 1'b1) incs++;
    if (vec_valid === 1'b1) vhit <= vec_addr;
    if (wr_ev === 1'b1) chk("write", exp_q.pop_front(), wr_rec);
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    step(5);
    rstn <= 1'b1;
    step(1);
    chk("flag", '0, interrupt_enable_flag);
    // random memory and port writes, some stretched by the far side
    for (int i = 0; i < 12; i++) begin
      rs = lfsr(rs);
      t = rs[0] ? 3'h3 : 3'h2;
      a = rs[0] ? {2{rs[15:8]}} : rs[15:0];
      exp_q.push_back({rs[0], a, rs[23:16]});
      slow <= rs[3];
      cyc(t, a, rs[23:16], i == 11);
    end
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      slow <= rs[2];
      cyc(3'h1, rs[15:0], '0, 1'b1);
      chk("rdata", rs[7:0] ^ 8'h5A, cyc_rdata);
    end
    cyc(3'h5, '0, '0, 1'b1);
    // maskable request answered by a call from the controller
    slow <= 1'b0;
    ei_set <= 1'b1;
    step(1);
    ei_set <= 1'b0;
    maskable_interrupt_request <= 1'b1;
    fetch_next <= 1'b1;
    step(8);
    exp_q.push_back({1'b0, sp_now - 16'h1, pc_now[15:8]});
    exp_q.push_back({1'b0, sp_now - 16'h2, pc_now[7:0]});
    n = incs;
    cyc(3'h0, pc_now, '0, 1'b1);
    maskable_interrupt_request <= 1'b0;
    chk("pc_inc", n, incs);
    chk("pc_load", 1, pc_load);
    chk("pc_new", 16'h1234, pc_new);
    chk("sp_new", sp_now - 16'h2, sp_new);
    chk("flag", 0, interrupt_enable_flag);
    // halt, a hold inside it, then a restart edge to leave
    step(6); // let the dropped request clear the synchroniser first
    ei_set <= 1'b1;
    step(1);
    ei_set <= 1'b0;
    halt_req <= 1'b1;
    n = 0;
    while (halted !== 1'b1 && n < 40) begin step(1); n++; end
    halt_req <= 1'b0;
    hold <= 1'b1;
    step(6);
    chk("pushes", 0, exp_q.size());
    chk("hlda", 1, hlda);
    hold <= 1'b0;
    step(6);
    chk("halted", 1, halted);
    rst_hi_in <= 1'b1;
    step(8);
    rst_hi_in <= 1'b0;
    cyc(3'h0, pc_now, '0, 1'b1);
    chk("vector", 16'h003C, vhit);
    chk("flag", 0, interrupt_enable_flag);
    chk("halted", 0, halted);
    tally_and_finish;
  end
endmodule
